// ---- inc/cms_pkg.sv ----
// Package of constants and types for the CPU mode and segment MMU.
//
// How it works
// - Five modes: startup, test, contactless OS, privileged, unprivileged.
// - Every reset starts in startup mode; applications can never enter it.
// - Unmaskable exceptions jump to a per-source vector in privileged mode.
// - Exceptions: breakpoint, fault, illegal, stack, syscall, unpriv return.
// - Virtual addresses map to RAM, ROM, EEPROM by the fixed partition; segments only gate access.
// - Up to 64 unprivileged segments; the partition itself is fixed.
// - Segments hold base, size, enable, R/W/X and peripheral rights.
// - Segments load from a descriptor table placed anywhere in memory.
// - Unprivileged accesses reach only memory covered by enabled segments.
// - Privileged code is unrestricted except for test registers and alone may configure the unit.
// - Unprivileged peripheral access follows the fetching segment's rights.
// - Test mode is fused off until the next reset and opens test registers.
// - The top 128 EEPROM bytes hold configuration and lifecycle data.
// - Apps never reach contactless OS; the firmware modes are elevated.
package cms_pkg;
  localparam int ADDR_W = 16;
  localparam int NSEG = 64;
  localparam int SEG_W = 6;
  localparam int PER_W = 8;
  // Fixed memory partition of the virtual space.
  localparam logic [15:0] ROM_BASE = 16'h0000;
  localparam logic [15:0] RAM_BASE = 16'h8000;
  localparam logic [15:0] EE_BASE = 16'hA000;
  localparam logic [15:0] EE_TOP = 16'hFFFF;
  localparam logic [15:0] CFG_ROW_BYTES = 16'h0080;
  localparam logic [15:0] CFG_ROW_BASE = 16'hFF80;
  // Peripheral register window.
  localparam logic [7:0] PER_TEST_FIRST = 8'hF0;
  // Exception vectors.
  localparam logic [15:0] VEC_BREAK = 16'h0010;
  localparam logic [15:0] VEC_FAULT = 16'h0018;
  localparam logic [15:0] VEC_ILLEGAL = 16'h0020;
  localparam logic [15:0] VEC_STACK = 16'h0028;
  localparam logic [15:0] VEC_SYSCALL = 16'h0030;
  localparam logic [15:0] VEC_RETURN = 16'h0038;
  localparam logic [15:0] VEC_ACCESS = 16'h0040;
  // APB register byte addresses.
  localparam logic [11:0] A_MODE = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_MASK = 12'h008;
  localparam logic [11:0] A_TABLE = 12'h00C;
  localparam logic [11:0] A_LOAD = 12'h010;
  localparam logic [11:0] A_FUSE = 12'h014;
  localparam logic [11:0] A_VECTOR = 12'h018;
  localparam logic [11:0] A_PERRIGHT = 12'h01C;
  localparam logic [6:0] EV_W = 7'h7F;

  typedef enum logic [2:0] {
    M_STARTUP, M_FACTORY, M_CONTACTLESS, M_PRIV, M_UNPRIV
  } cms_mode_e;

  typedef struct packed {
    logic en;
    logic rd;
    logic wr;
    logic ex;
    logic [15:0] base;
    logic [15:0] size;
    logic [PER_W-1:0] per;
  } cms_seg_s;

  typedef struct packed {
    logic breakpoint;
    logic fault;
    logic illegal;
    logic stack;
    logic syscall;
    logic ret_unpriv;
  } cms_exc_s;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic [15:0] addr;
  } cms_mreq_s;
endpackage : cms_pkg

// ---- src/cms_seg_check.sv ----
// Segment table lookup that decides whether an unprivileged access hits.
`timescale 1ns/1ns
`default_nettype none
module cms_seg_check
  import cms_pkg::*;
#(
  parameter int N = NSEG
) (
  input wire cms_seg_s segs [N],
  input wire logic [15:0] addr,
  input wire logic need_rd,
  input wire logic need_wr,
  input wire logic need_ex,
  output logic hit,
  output logic allowed,
  output logic [SEG_W-1:0] index
);
  function automatic logic covers(cms_seg_s s, logic [15:0] a);
    logic [16:0] lim;
    lim = {1'b0, s.base} + {1'b0, s.size};
    covers = s.en && (a >= s.base) && ({1'b0, a} < lim);
  endfunction : covers

  always_comb begin
    hit = 1'b0;
    allowed = 1'b0;
    index = '0;
    // Lowest numbered enabled segment that covers the address wins.
    for (int i = N - 1; i >= 0; i--) begin
      if (covers(segs[i], addr)) begin
        hit = 1'b1;
        index = SEG_W'(i);
        allowed = (!need_rd || segs[i].rd) && (!need_wr || segs[i].wr)
                  && (!need_ex || segs[i].ex);
      end
    end
  end
endmodule : cms_seg_check
`default_nettype wire

// ---- src/cms_mmu.sv ----
// CPU mode control and segment based memory management unit.
`timescale 1ns/1ns
`default_nettype none
module cms_mmu
  import cms_pkg::*;
#(
  parameter int N = NSEG
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cms_mreq_s cpu_req,
  input wire cms_exc_s cpu_exc,
  input wire logic per_valid,
  input wire logic per_write,
  input wire logic [7:0] per_addr,
  input wire logic [15:0] tbl_rdata,
  input wire logic tbl_rvalid,
  output logic tbl_req,
  output logic [15:0] tbl_addr,
  output logic mem_valid,
  output logic [1:0] mem_region,
  output logic [15:0] mem_paddr,
  output logic per_grant,
  output logic exc_take,
  output logic [15:0] exc_vector,
  output logic [2:0] cpu_mode,
  output logic elevated,
  output logic irq
);
  localparam logic [1:0] R_ROM = 2'h0;
  localparam logic [1:0] R_RAM = 2'h1;
  localparam logic [1:0] R_EE = 2'h2;
  localparam logic [2:0] WORDS = 3'h4;

  cms_mode_e mode, next_mode;
  logic fused, next_fused;
  logic [6:0] status, next_status, mask, next_mask;
  logic [15:0] tbl_base, next_tbl_base;
  logic [SEG_W-1:0] fetch_seg, next_fetch_seg;
  cms_seg_s segs [N];
  cms_seg_s next_segs [N];
  logic loading, next_loading;
  logic tbl_wait, next_tbl_wait;
  logic [SEG_W:0] ld_seg, next_ld_seg;
  logic [2:0] ld_word, next_ld_word;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_tbl_req;
  logic [15:0] next_tbl_addr, next_mem_paddr, next_vector;
  logic next_mem_valid, next_per_grant, next_exc_take;
  logic [1:0] next_region;
  logic hit, allowed;
  logic [SEG_W-1:0] hit_idx;
  logic [15:0] vec;
  logic any_exc, blocked, cfg_write;

  cms_seg_check #(.N(N)) u_check (
    .segs(segs),
    .addr(cpu_req.addr),
    .need_rd(!cpu_req.write && !cpu_req.fetch),
    .need_wr(cpu_req.write),
    .need_ex(cpu_req.fetch),
    .hit(hit),
    .allowed(allowed),
    .index(hit_idx)
  );

  function automatic logic [1:0] region_of(logic [15:0] a);
    if (a >= EE_BASE) region_of = R_EE;
    else if (a >= RAM_BASE) region_of = R_RAM;
    else region_of = R_ROM;
  endfunction : region_of

  function automatic logic [15:0] phys_of(logic [15:0] a);
    if (a >= EE_BASE) phys_of = a - EE_BASE;
    else if (a >= RAM_BASE) phys_of = a - RAM_BASE;
    else phys_of = a - ROM_BASE;
  endfunction : phys_of

  function automatic logic is_priv(cms_mode_e m);
    is_priv = (m != M_UNPRIV);
  endfunction : is_priv

  always_comb begin
    vec = VEC_BREAK;
    // Highest priority source selects the fixed vector.
    if (cpu_exc.breakpoint) vec = VEC_BREAK;
    else if (cpu_exc.fault) vec = VEC_FAULT;
    else if (cpu_exc.illegal) vec = VEC_ILLEGAL;
    else if (cpu_exc.stack) vec = VEC_STACK;
    else if (cpu_exc.syscall) vec = VEC_SYSCALL;
    else if (cpu_exc.ret_unpriv && mode == M_UNPRIV) vec = VEC_RETURN;
    else vec = VEC_ACCESS;
  end

  always_comb begin
    // Unprivileged accesses outside segments or permission are blocked.
    // Application writes never touch the reserved top row.
    blocked = cpu_req.valid && mode == M_UNPRIV
              && (!(hit && allowed)
              || (cpu_req.write && cpu_req.addr >= CFG_ROW_BASE));
    any_exc = cpu_exc.breakpoint || cpu_exc.fault || cpu_exc.illegal
              || cpu_exc.stack || cpu_exc.syscall
              || (cpu_exc.ret_unpriv && mode == M_UNPRIV) || blocked;
    // Only privileged code may configure the unit.
    cfg_write = psel && penable && pwrite && mode == M_PRIV && !loading;
  end

  always_comb begin
    next_mode = mode;
    next_fused = fused;
    next_status = status;
    next_mask = mask;
    next_tbl_base = tbl_base;
    next_fetch_seg = fetch_seg;
    next_segs = segs;
    next_loading = loading;
    next_ld_seg = ld_seg;
    next_ld_word = ld_word;
    next_prdata = 32'h0000_0000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_tbl_req = 1'b0;
    next_tbl_wait = tbl_wait;
    next_tbl_addr = tbl_addr;
    next_mem_valid = 1'b0;
    next_region = mem_region;
    next_mem_paddr = mem_paddr;
    next_per_grant = 1'b0;
    next_exc_take = 1'b0;
    next_vector = exc_vector;
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      unique case (paddr)
        A_MODE: next_prdata = {29'h0, mode};
        A_STATUS: next_prdata = {25'h0, status};
        A_MASK: next_prdata = {25'h0, mask};
        A_TABLE: next_prdata = {16'h0, tbl_base};
        A_LOAD: next_prdata = {31'h0, loading};
        A_FUSE: next_prdata = {31'h0, fused};
        A_VECTOR: next_prdata = {16'h0, exc_vector};
        A_PERRIGHT: next_prdata = {24'h0, segs[fetch_seg].per};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite && !cfg_write && paddr != A_STATUS) next_pslverr = 1'b1;
      if (cfg_write) begin
        unique case (paddr)
          A_MASK: next_mask = pwdata[6:0];
          A_TABLE: next_tbl_base = pwdata[15:0];
          A_LOAD: begin
            // Segments are loaded from the descriptor table.
            next_loading = pwdata[0];
            next_ld_seg = '0;
            next_ld_word = '0;
          end
          // Test mode is disabled once fused, until the next reset.
          A_FUSE: next_fused = fused | pwdata[0];
          A_MODE: if (pwdata[2:0] == 3'(M_UNPRIV)) next_mode = M_UNPRIV;
          default: ;
        endcase
      end
      if (pwrite && paddr == A_STATUS) begin
        next_status = status & ~pwdata[6:0];
      end
    end
    if (tbl_req) next_tbl_wait = 1'b1;
    if (tbl_rvalid) next_tbl_wait = 1'b0;
    if (loading) begin
      // Only one descriptor word is outstanding at a time.
      next_tbl_req = !tbl_req && !tbl_wait && !tbl_rvalid;
      next_tbl_addr = tbl_base + {8'h00, ld_seg[SEG_W-1:0], ld_word[1:0]};
      if (tbl_rvalid) begin
        unique case (ld_word)
          3'h0: begin
            next_segs[ld_seg[SEG_W-1:0]].en = tbl_rdata[15];
            next_segs[ld_seg[SEG_W-1:0]].rd = tbl_rdata[14];
            next_segs[ld_seg[SEG_W-1:0]].wr = tbl_rdata[13];
            next_segs[ld_seg[SEG_W-1:0]].ex = tbl_rdata[12];
          end
          3'h1: next_segs[ld_seg[SEG_W-1:0]].base = tbl_rdata;
          3'h2: next_segs[ld_seg[SEG_W-1:0]].size = tbl_rdata;
          default: next_segs[ld_seg[SEG_W-1:0]].per = tbl_rdata[PER_W-1:0];
        endcase
        if (ld_word == WORDS - 3'h1) begin
          next_ld_word = '0;
          next_ld_seg = ld_seg + 1'b1;
          if (ld_seg == (SEG_W+1)'(N - 1)) next_loading = 1'b0;
        end else begin
          next_ld_word = ld_word + 3'h1;
        end
      end
    end
    if (cpu_req.valid && !blocked) begin
      // Fixed partition mapping to physical memories.
      next_mem_valid = 1'b1;
      next_region = region_of(cpu_req.addr);
      next_mem_paddr = phys_of(cpu_req.addr);
      if (mode == M_UNPRIV && cpu_req.fetch) next_fetch_seg = hit_idx;
    end
    if (per_valid) begin
      if (per_addr >= PER_TEST_FIRST)
        next_per_grant = mode == M_FACTORY && !fused;
      else if (mode == M_UNPRIV)
        next_per_grant = segs[fetch_seg].per[per_addr[2:0]];
      else
        next_per_grant = 1'b1;
    end
    if (mode == M_STARTUP) begin
      // Firmware leaves start-up to test or OS; never reached by apps.
      next_mode = fused ? M_CONTACTLESS : M_FACTORY;
    end else if (mode == M_FACTORY && fused) begin
      next_mode = M_CONTACTLESS;
    end else if (mode == M_CONTACTLESS) begin
      next_mode = M_PRIV;
    end
    if (any_exc) begin
      next_exc_take = 1'b1;
      next_vector = vec;
      next_mode = M_PRIV;
      next_status = next_status | {blocked, cpu_exc.ret_unpriv && mode
        == M_UNPRIV, cpu_exc.syscall, cpu_exc.stack, cpu_exc.illegal,
        cpu_exc.fault, cpu_exc.breakpoint};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode <= M_STARTUP;
      fused <= 1'b0;
      status <= '0;
      mask <= '0;
      tbl_base <= '0;
      fetch_seg <= '0;
      loading <= 1'b0;
      ld_seg <= '0;
      ld_word <= '0;
      for (int i = 0; i < N; i++) segs[i] <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tbl_req <= 1'b0;
      tbl_wait <= 1'b0;
      tbl_addr <= '0;
      mem_valid <= 1'b0;
      mem_region <= R_ROM;
      mem_paddr <= '0;
      per_grant <= 1'b0;
      exc_take <= 1'b0;
      exc_vector <= '0;
      cpu_mode <= 3'(M_STARTUP);
      elevated <= 1'b1;
      irq <= 1'b0;
    end else begin
      mode <= next_mode;
      fused <= next_fused;
      status <= next_status;
      mask <= next_mask;
      tbl_base <= next_tbl_base;
      fetch_seg <= next_fetch_seg;
      loading <= next_loading;
      ld_seg <= next_ld_seg;
      ld_word <= next_ld_word;
      segs <= next_segs;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      tbl_req <= next_tbl_req;
      tbl_wait <= next_tbl_wait;
      tbl_addr <= next_tbl_addr;
      mem_valid <= next_mem_valid;
      mem_region <= next_region;
      mem_paddr <= next_mem_paddr;
      per_grant <= next_per_grant;
      exc_take <= next_exc_take;
      exc_vector <= next_vector;
      cpu_mode <= 3'(next_mode);
      elevated <= next_mode != M_PRIV && next_mode != M_UNPRIV;
      irq <= |(next_status & next_mask);
    end
  end

  exc_mode_a: assert property (@(posedge clock) disable iff (!rstn)
    exc_take |-> cpu_mode == 3'(M_PRIV)) else $error("exception not priv");
  reset_mode_a: assert property (@(posedge clock)
    $rose(rstn) |-> cpu_mode == 3'(M_STARTUP)) else $error("no startup");
  block_seg_a: assert property (@(posedge clock) disable iff (!rstn)
    blocked |=> !mem_valid && exc_take) else $error("access leaked");
  fuse_keep_a: assert property (@(posedge clock) disable iff (!rstn)
    fused |=> fused) else $error("fuse cleared");
  test_per_a: assert property (@(posedge clock) disable iff (!rstn)
    per_grant && fused |-> $past(per_addr) < PER_TEST_FIRST)
    else $error("test register granted");
  elev_mode_a: assert property (@(posedge clock) disable iff (!rstn)
    elevated == (cpu_mode != 3'(M_PRIV) && cpu_mode != 3'(M_UNPRIV)))
    else $error("elevated wrong");
  ret_vec_a: assert property (@(posedge clock) disable iff (!rstn)
    cpu_exc.ret_unpriv && mode == M_UNPRIV && !cpu_exc.syscall
    && !cpu_exc.stack && !cpu_exc.illegal && !cpu_exc.fault
    && !cpu_exc.breakpoint |=> exc_vector == VEC_RETURN)
    else $error("return vector wrong");
  unpriv_cfg_a: assert property (@(posedge clock) disable iff (!rstn)
    mode == M_UNPRIV && psel && penable && pwrite && paddr == A_MASK
    && !pready |=> $stable(mask)) else $error("unpriv config");
  irq_level_a: assert property (@(posedge clock) disable iff (!rstn)
    irq == |(status & mask)) else $error("irq wrong");
endmodule : cms_mmu
`default_nettype wire

// ---- test/cms_tbl_model.sv ----
// Descriptor table memory model that answers table word reads.
`timescale 1ns/1ns
`default_nettype none
module cms_tbl_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tbl_req,
  input wire logic [15:0] tbl_addr,
  output logic [15:0] tbl_rdata,
  output logic tbl_rvalid
);
  logic [15:0] mem [256];
  logic [7:0] addr_q;
  logic busy;
  logic slow;
  logic [1:0] wait_c;
  initial begin
    tbl_rdata = 16'h0000;
    tbl_rvalid = 1'b0;
  end
  // Every other read answers two cycles late; idle data toggles each cycle.
  always @(posedge clock) begin
    tbl_rvalid <= 1'b0;
    tbl_rdata <= ~tbl_rdata;
    if (!rstn) begin
      busy <= 1'b0;
      slow <= 1'b0;
    end else if (tbl_req) begin
      busy <= 1'b1;
      addr_q <= tbl_addr[7:0];
      wait_c <= slow ? 2'h2 : 2'h0;
      slow <= ~slow;
    end else if (busy && wait_c != 2'h0) begin
      wait_c <= wait_c - 2'h1;
    end else if (busy) begin
      tbl_rvalid <= 1'b1;
      tbl_rdata <= mem[addr_q];
      busy <= 1'b0;
    end
  end
endmodule : cms_tbl_model
`default_nettype wire

// ---- test/cms_mmu_test.sv ----
// Self-checking testbench for the CPU mode and segment MMU.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; \
  if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module cms_mmu_test
  import cms_pkg::*;
();
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, er, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  cms_mreq_s cpu_req;
  cms_exc_s cpu_exc;
  logic per_valid, per_write, per_grant, exc_take, elevated, irq;
  logic [7:0] per_addr;
  logic [15:0] tbl_rdata, tbl_addr, mem_paddr, exc_vector, a;
  logic tbl_rvalid, tbl_req, mem_valid, f, w;
  logic [1:0] mem_region;
  logic [2:0] cpu_mode;
  int err_count, n_checks, cyc, seed, n;
  logic [15:0] sb [3] = '{16'h8000, 16'hA000, 16'hFF00};
  logic [15:0] sz [3] = '{16'h0100, 16'h0100, 16'h00F0};
  logic [3:0] sfl [3] = '{4'hD, 4'hE, 4'hE};
  logic [15:0] picks [5] = '{16'h0000, 16'h8000, 16'h9000, 16'hA000, 16'hFF00};

  cms_mmu uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_exc(cpu_exc),
    .per_valid(per_valid), .per_write(per_write), .per_addr(per_addr),
    .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .mem_valid(mem_valid), .mem_region(mem_region),
    .mem_paddr(mem_paddr), .per_grant(per_grant), .exc_take(exc_take),
    .exc_vector(exc_vector), .cpu_mode(cpu_mode), .elevated(elevated),
    .irq(irq));
  cms_tbl_model tm (.clock(clock), .rstn(rstn), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [15:0] exp_vec(input logic [5:0] v);
    if (v[5]) return VEC_BREAK;
    if (v[4]) return VEC_FAULT;
    if (v[3]) return VEC_ILLEGAL;
    if (v[2]) return VEC_STACK;
    if (v[1]) return VEC_SYSCALL;
    return VEC_RETURN;
  endfunction : exp_vec

  function automatic logic exp_ok(input logic [15:0] ad, input logic fe,
                                  input logic wr);
    for (int s = 0; s < 3; s++) begin
      if (ad >= sb[s] && ad - sb[s] < sz[s])
        return (fe ? sfl[s][0] : wr ? sfl[s][1] : sfl[s][2]) &&
               !(wr && ad >= CFG_ROW_BASE);
    end
    return 1'b0;
  endfunction : exp_ok

  function automatic logic [17:0] exp_map(input logic [15:0] ad);
    if (ad >= EE_BASE) return {2'h2, ad - EE_BASE};
    if (ad >= RAM_BASE) return {2'h1, ad - RAM_BASE};
    return {2'h0, ad - ROM_BASE};
  endfunction : exp_map

  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic to_user;
    apb(1'b1, A_MODE, 32'h0000_0004);
    @(negedge clock);
    `CHK("cpu_mode", 3'h4, cpu_mode)
    `CHK("elevated", 1'b0, elevated)
  endtask : to_user

  task automatic acc(input logic [15:0] ad, input logic fe, input logic wr,
                     input logic priv);
    logic [17:0] m;
    @(posedge clock);
    cpu_req <= '{1'b1, fe, wr, ad};
    @(posedge clock);
    cpu_req <= '0;
    @(negedge clock);
    ok = priv | exp_ok(ad, fe, wr);
    m = exp_map(ad);
    `CHK("mem_valid", ok, mem_valid)
    `CHK("exc_take", !ok, exc_take)
    if (ok) begin
      `CHK("mem_region", m[17:16], mem_region)
      `CHK("mem_paddr", m[15:0], mem_paddr)
    end else begin
      `CHK("exc_vector", VEC_ACCESS, exc_vector)
    end
    if (!ok) to_user();
  endtask : acc

  task automatic exc(input logic [5:0] v);
    @(posedge clock);
    cpu_exc <= v;
    @(posedge clock);
    cpu_exc <= '0;
    @(negedge clock);
    `CHK("exc_take", 1'b1, exc_take)
    `CHK("exc_vector", exp_vec(v), exc_vector)
    `CHK("cpu_mode", 3'h3, cpu_mode)
  endtask : exc

  task automatic per(input logic [7:0] ad, input logic ex);
    @(posedge clock);
    per_valid <= 1'b1;
    per_write <= 1'($random(seed));
    per_addr <= ad;
    @(posedge clock);
    per_valid <= 1'b0;
    @(negedge clock);
    `CHK("per_grant", ex, per_grant)
  endtask : per

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {rstn, psel, penable, pwrite, per_valid, per_write} = '0;
    paddr = '0;
    pwdata = '0;
    per_addr = '0;
    cpu_req = '0;
    cpu_exc = '0;
    seed = 32;
    for (int i = 0; i < 256; i++) tm.mem[i] = 16'h0000;
    for (int s = 0; s < 3; s++) begin
      tm.mem[4 * s] = {sfl[s], 12'h000};
      tm.mem[4 * s + 1] = sb[s];
      tm.mem[4 * s + 2] = sz[s];
      tm.mem[4 * s + 3] = (s == 0) ? 16'h0005 : 16'h0000;
    end
    repeat (3) @(posedge clock);
    @(negedge clock);
    `CHK("cpu_mode", 3'h0, cpu_mode)
    @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("elevated", 1'b1, elevated)
    per(8'hF2, 1'b1);
    apb(1'b1, A_MODE, 32'h0000_0004);
    `CHK("pslverr", 1'b1, er)
    for (int i = 1; i < 6; i++) exc(6'h01 << i);
    repeat (8) exc((6'($random(seed)) & 6'h3E) | 6'h02);
    apb(1'b1, A_MASK, 32'h0000_0000);
    apb(0, A_STATUS, 32'h0);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, A_MASK, 32'h0000_007F);
    apb(0, A_MASK, 32'h0);
    `CHK("mask", 32'h0000_007F, rd)
    `CHK("irq", 1'b1, irq)
    apb(1'b1, A_STATUS, 32'h0000_007F);
    repeat (2) @(negedge clock);
    `CHK("irq", 1'b0, irq)
    apb(0, 12'hFFC, 32'h0);
    `CHK("pslverr", 1'b1, er)
    apb(1'b1, A_TABLE, 32'h0000_0100);
    apb(1'b1, A_LOAD, 32'h0000_0001);
    n = 0;
    do begin
      apb(0, A_LOAD, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    `CHK("load", 1'b0, rd[0])
    repeat (10) acc(16'($random(seed)), 0, 1'($random(seed)), 1);
    to_user();
    acc(16'hFF10, 0, 1, 0);
    acc(16'hFF80, 0, 1, 0);
    apb(0, A_STATUS, 32'h0);
    `CHK("status", 1'b1, rd[6])
    to_user();
    repeat (40) begin
      a = picks[{$random(seed)} % 5] + 16'({$random(seed)} % 256);
      f = 1'($random(seed));
      w = f ? 1'b0 : 1'($random(seed));
      acc(a, f, w, 0);
    end
    acc(16'h8010, 1, 0, 0);
    for (int i = 0; i < 8; i++) per(8'(i), i == 0 || i == 2);
    per(8'hF2, 1'b0);
    apb(1'b1, A_MASK, 32'h0000_0000);
    `CHK("pslverr", 1'b1, er)
    `CHK("irq", 1'b1, irq)
    apb(1'b1, A_MODE, 32'h0000_0003);
    `CHK("pslverr", 1'b1, er)
    `CHK("cpu_mode", 3'h4, cpu_mode)
    exc(6'h01);
    apb(1'b1, A_FUSE, 32'h0000_0001);
    `CHK("pslverr", 1'b0, er)
    apb(0, A_FUSE, 32'h0);
    `CHK("fuse", 32'h0000_0001, rd)
    per(8'hF2, 1'b0);
    per(8'h02, 1'b1);
    test_done();
  end
endmodule : cms_mmu_test
`default_nettype wire
